/* File: htf_map.svh */
// Named offsets, field positions, reset values and timing figures of the frame readout.
// What the document requires of this block and its host
// R1: 20ms reset, then one measurement unasked.
// R2: Request already low after reset: send frame.
// R3: Host keeps request high unless reading.
// R4: Push-pull output, low when idle, bits while requested.
// R5: Request high aborts the frame at once.
// R6: After transfer, measure once more, then sleep.
// R7: Send temp hi, lo, humidity, ext hi, lo, checksum.
// R8: Temperature is tenths plus 0190 hex offset.
// R9: High pulse 1.5ms zero, 500us one; 10ms interval.
// R10: Last byte is CRC-8, polynomial x8+x5+x4; code shifts in 1 on feedback, i.e. x8+x5+x4+1.
// R11: Host checks checksum and resets on mismatch; the htf_host_rx model does neither.
// R12: CRC starts zero, shifts, flips bits 4,5.
// R13: Host splits pulses at midway threshold.
`ifndef HTF_MAP_SVH
`define HTF_MAP_SVH

// ==========================================================================
// Clock and timing figures
`define HTF_CLK_MHZ        25
`define HTF_T_RESET_US     20000
`define HTF_T_INTERVAL_US  10000
`define HTF_T_ZERO_US      1500
`define HTF_T_ONE_US       500
`define HTF_T_GAP_US       500
`define HTF_CNT_W          20

// ==========================================================================
// Frame layout
`define HTF_FRAME_W        48
`define HTF_PAYLOAD_W      40
`define HTF_FRAME_BYTES    3'h6
`define HTF_BYTE_W         8
`define HTF_MSB_IDX        3'h7
`define HTF_TEMP_OFFSET    16'h0190

// ==========================================================================
// Checksum
`define HTF_CRC_INIT       8'h00
`define HTF_CRC_FLIP       8'h30

// ==========================================================================
// Buffer
`define HTF_FIFO_DEPTH     16

`endif

/* File: htf_pkg.sv */
// Types shared by the frame readout modules.
package htf_pkg;

    // ==========================================================================
    // Sequencer states
    typedef enum logic [7:0] {
        HTF_ST_RESET = 8'h01,
        HTF_ST_MEAS  = 8'h02,
        HTF_ST_SLEEP = 8'h04,
        HTF_ST_LEAD  = 8'h08,
        HTF_ST_FETCH = 8'h10,
        HTF_ST_PULSE = 8'h20,
        HTF_ST_GAP   = 8'h40,
        HTF_ST_HOLD  = 8'h80
    } htf_state_t;

endpackage

/* File: htf_fifo.sv */
// Byte buffer between the frame loader and the bit serialiser.
`timescale 1ns/1ps
`default_nettype none

module htf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } htf_fifo_state_t;

    htf_fifo_state_t s_q;
    htf_fifo_state_t s_d;
    logic            push;
    logic            pop;

    assign in_ready  = (s_q.count != (PW+1)'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data  = s_q.mem[s_q.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ==========================================================================
    // Pointer and storage update
    always_comb begin
        s_d = s_q;
        if (flush) begin
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.count  = '0;
        end else begin
            if (push) begin
                s_d.mem[s_q.wr_ptr] = in_data;
                s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
            end
            if (pop) begin
                s_d.rd_ptr = s_q.rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                s_d.count = s_q.count + 1'b1;
            end else if (pop && !push) begin
                s_d.count = s_q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // htf_fifo

`default_nettype wire

/* File: htf_readout.sv */
// Measurement sequencer and pulse-width frame transmitter of the sensor module.
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.svh"

module htf_readout #(
    parameter int RESET_CYC    = `HTF_T_RESET_US * `HTF_CLK_MHZ,
    parameter int INTERVAL_CYC = `HTF_T_INTERVAL_US * `HTF_CLK_MHZ,
    parameter int ZERO_CYC     = `HTF_T_ZERO_US * `HTF_CLK_MHZ,
    parameter int ONE_CYC      = `HTF_T_ONE_US * `HTF_CLK_MHZ,
    parameter int GAP_CYC      = `HTF_T_GAP_US * `HTF_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Serial link
    input  wire logic        read_req_n,
    output logic             serial_data,
    // Sensor front end
    output logic             meas_start,
    input  wire logic        meas_done,
    input  wire logic [15:0] meas_temp_tenths,
    input  wire logic [7:0]  meas_humidity,
    input  wire logic [15:0] meas_ext_temp_tenths,
    // Status
    output logic             power_on_control
);

    // ==========================================================================
    // State
    typedef struct packed {
        htf_pkg::htf_state_t         state;
        logic [`HTF_CNT_W-1:0]       cnt;
        logic [`HTF_BYTE_W-1:0]      shift;
        logic [2:0]                  bit_idx;
        logic [2:0]                  load_idx;
        logic [2:0]                  sent;
        logic [`HTF_FRAME_W-1:0]     frame;
        logic                        data;
        logic                        meas_start;
    } htf_core_t;

    htf_core_t              s_q;
    htf_core_t              s_d;

    logic                   in_valid;
    logic                   in_ready;
    logic [`HTF_BYTE_W-1:0] in_data;
    logic                   out_valid;
    logic                   out_ready;
    logic [`HTF_BYTE_W-1:0] out_data;
    logic                   in_transfer;
    logic                   abort;
    logic [15:0]            temp_code;
    logic [15:0]            ext_code;
    logic [`HTF_PAYLOAD_W-1:0] payload;

    // ==========================================================================
    // Checksum
    // Bitwise form is kept because it runs once per measurement; a byte table
    // would cost a 256-entry constant for no gain at this rate.
    function automatic logic [7:0] htf_crc8(input logic [`HTF_PAYLOAD_W-1:0] d);
        logic [7:0] c;
        c = `HTF_CRC_INIT; // [R12]
        for (int i = `HTF_PAYLOAD_W - 1; i >= 0; i--) begin
            if (d[i] != c[7]) begin
                c = {c[6:0], 1'b1} ^ `HTF_CRC_FLIP; // [R10] [R12]
            end else begin
                c = {c[6:0], 1'b0}; // [R12]
            end
        end
        return c;
    endfunction

    // ==========================================================================
    // Frame assembly
    assign temp_code = meas_temp_tenths + `HTF_TEMP_OFFSET; // [R8]
    assign ext_code  = meas_ext_temp_tenths + `HTF_TEMP_OFFSET; // [R8]
    assign payload   = {temp_code, meas_humidity, ext_code}; // [R7]

    // ==========================================================================
    // Transfer window and abort
    assign in_transfer = (s_q.state == htf_pkg::HTF_ST_LEAD)
                      || (s_q.state == htf_pkg::HTF_ST_FETCH)
                      || (s_q.state == htf_pkg::HTF_ST_PULSE)
                      || (s_q.state == htf_pkg::HTF_ST_GAP)
                      || (s_q.state == htf_pkg::HTF_ST_HOLD);
    assign abort       = in_transfer && read_req_n; // [R5]

    // ==========================================================================
    // Loader: streams the stored frame into the buffer, stalled by its ready.
    assign in_valid  = in_transfer && !read_req_n && (s_q.load_idx != `HTF_FRAME_BYTES);
    assign in_data   = s_q.frame[`HTF_FRAME_W - 1 - `HTF_BYTE_W * s_q.load_idx -: `HTF_BYTE_W]; // [R7]
    assign out_ready = (s_q.state == htf_pkg::HTF_ST_FETCH) && !read_req_n;

    htf_fifo #(
        .WIDTH (`HTF_BYTE_W),
        .DEPTH (`HTF_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .flush     (abort),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ==========================================================================
    // Sequencer
    always_comb begin
        s_d            = s_q;
        s_d.meas_start = 1'b0;
        if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        if (in_valid && in_ready) begin
            s_d.load_idx = s_q.load_idx + 1'b1;
        end

        if (abort) begin
            // Leaving the link in any bit: line low, buffer flushed, one more
            // conversion so the next read is served from stored data.
            s_d.state      = htf_pkg::HTF_ST_MEAS; // [R5] [R6]
            s_d.meas_start = 1'b1; // [R6]
            s_d.data       = 1'b0; // [R4]
            s_d.load_idx   = '0;
            s_d.sent       = '0;
            s_d.cnt        = '0;
        end else begin
            unique case (s_q.state)
                htf_pkg::HTF_ST_RESET: begin
                    s_d.data = 1'b0;
                    if (s_q.cnt == '0) begin
                        s_d.state      = htf_pkg::HTF_ST_MEAS; // [R1]
                        s_d.meas_start = 1'b1; // [R1]
                    end
                end
                htf_pkg::HTF_ST_MEAS: begin
                    s_d.data = 1'b0;
                    if (meas_done) begin
                        s_d.frame    = {payload, htf_crc8(payload)}; // [R7] [R10]
                        s_d.load_idx = '0;
                        s_d.sent     = '0;
                        if (!read_req_n) begin
                            s_d.state = htf_pkg::HTF_ST_LEAD; // [R2]
                            s_d.cnt   = `HTF_CNT_W'(INTERVAL_CYC - 1); // [R9]
                        end else begin
                            s_d.state = htf_pkg::HTF_ST_SLEEP; // [R6]
                        end
                    end
                end
                htf_pkg::HTF_ST_SLEEP: begin
                    s_d.data = 1'b0; // [R4]
                    if (!read_req_n) begin
                        s_d.state    = htf_pkg::HTF_ST_LEAD;
                        s_d.cnt      = `HTF_CNT_W'(INTERVAL_CYC - 1); // [R9]
                        s_d.load_idx = '0;
                        s_d.sent     = '0;
                    end
                end
                htf_pkg::HTF_ST_LEAD: begin
                    if (s_q.cnt == '0) begin
                        s_d.state = htf_pkg::HTF_ST_FETCH;
                    end
                end
                htf_pkg::HTF_ST_FETCH: begin
                    if (out_valid) begin
                        s_d.shift   = out_data;
                        s_d.bit_idx = `HTF_MSB_IDX; // [R7]
                        s_d.sent    = s_q.sent + 1'b1;
                        s_d.state   = htf_pkg::HTF_ST_PULSE;
                        s_d.data    = 1'b1; // [R4]
                        s_d.cnt     = out_data[`HTF_BYTE_W-1] ? `HTF_CNT_W'(ONE_CYC - 1)
                                                              : `HTF_CNT_W'(ZERO_CYC - 1); // [R9]
                    end
                end
                htf_pkg::HTF_ST_PULSE: begin
                    if (s_q.cnt == '0) begin
                        s_d.state = htf_pkg::HTF_ST_GAP;
                        s_d.data  = 1'b0;
                        s_d.cnt   = `HTF_CNT_W'(GAP_CYC - 1);
                    end
                end
                htf_pkg::HTF_ST_GAP: begin
                    if (s_q.cnt == '0) begin
                        if (s_q.bit_idx != '0) begin
                            s_d.bit_idx = s_q.bit_idx - 1'b1;
                            s_d.shift   = {s_q.shift[`HTF_BYTE_W-2:0], 1'b0}; // [R7]
                            s_d.state   = htf_pkg::HTF_ST_PULSE;
                            s_d.data    = 1'b1;
                            s_d.cnt     = s_q.shift[`HTF_BYTE_W-2] ? `HTF_CNT_W'(ONE_CYC - 1)
                                                                   : `HTF_CNT_W'(ZERO_CYC - 1); // [R9]
                        end else if (s_q.sent == `HTF_FRAME_BYTES) begin
                            s_d.state = htf_pkg::HTF_ST_HOLD;
                        end else begin
                            s_d.state = htf_pkg::HTF_ST_FETCH;
                        end
                    end
                end
                htf_pkg::HTF_ST_HOLD: begin
                    // A finished frame is not resent; the line rests low until
                    // the request is withdrawn, which then starts the conversion.
                    s_d.data = 1'b0; // [R4]
                end
                default: begin
                    s_d.state = htf_pkg::HTF_ST_RESET;
                    s_d.data  = 1'b0;
                    s_d.cnt   = `HTF_CNT_W'(RESET_CYC - 1);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.state <= htf_pkg::HTF_ST_RESET;
            s_q.cnt   <= `HTF_CNT_W'(RESET_CYC - 1); // [R1]
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    assign serial_data      = s_q.data; // [R4]
    assign meas_start       = s_q.meas_start;
    assign power_on_control = (s_q.state != htf_pkg::HTF_ST_SLEEP); // [R6]

endmodule // htf_readout

`default_nettype wire

/* File: htf_readout_end.sv */
// Holds no logic of its own; the frame readout lives in htf_readout.sv.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: htf_readout_properties.sv */
// Concurrent checks on the ports of the frame readout.
`timescale 1ns/1ps
`default_nettype none

module htf_readout_props #(
    parameter int RESET_CYC    = 20,
    parameter int INTERVAL_CYC = 10,
    parameter int ZERO_CYC     = 6,
    parameter int ONE_CYC      = 2,
    parameter int GAP_CYC      = 2
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Serial link
    input wire logic        read_req_n,
    input wire logic        serial_data,
    // Sensor front end
    input wire logic        meas_start,
    input wire logic        meas_done,
    input wire logic [15:0] meas_temp_tenths,
    input wire logic [7:0]  meas_humidity,
    input wire logic [15:0] meas_ext_temp_tenths,
    // Status
    input wire logic        power_on_control
);
    typedef struct packed {
        logic [19:0] hi_cnt;
        logic [19:0] lo_cnt;
        logic [19:0] boot_cnt;
        logic [19:0] lead_cnt;
        logic        armed;
        logic        started;
        logic        frame_seen;
        logic        meas_pend;
    } htf_chk_t;
    htf_chk_t h_q;
    htf_chk_t h_d;

    // ==========================================================================
    // Helper counters
    always_comb begin
        h_d = h_q;
        h_d.hi_cnt = serial_data ? h_q.hi_cnt + 20'h00001 : 20'h00000;
        h_d.lo_cnt = serial_data ? 20'h00000 : h_q.lo_cnt + 20'h00001;
        h_d.lead_cnt = h_q.lead_cnt + 20'h00001;
        if (h_q.boot_cnt != 20'hFFFFF) begin
            h_d.boot_cnt = h_q.boot_cnt + 20'h00001;
        end
        // A lead starts when a request meets a finished measurement or a sleeping module.
        if (!read_req_n && ((h_q.meas_pend && meas_done) || !power_on_control)) begin
            h_d.armed = 1'b1;
            h_d.lead_cnt = 20'h00000;
        end else if (serial_data || read_req_n) begin
            h_d.armed = 1'b0;
        end
        if (meas_start) begin
            h_d.started = 1'b1;
            h_d.meas_pend = 1'b1;
            h_d.frame_seen = 1'b0;
        end else if (serial_data) begin
            h_d.frame_seen = 1'b1;
        end
        if (meas_done) begin
            h_d.meas_pend = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    // ==========================================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    AST_ABORT_LOW: assert property (read_req_n |=> !serial_data)
        else $error("serial line not low after request release");
    AST_SLEEP_LOW: assert property (!power_on_control |-> !serial_data)
        else $error("serial line active while powered down");
    AST_PULSE_WIDTH: assert property ($fell(serial_data) && !$past(read_req_n)
        |-> (h_q.hi_cnt == ONE_CYC || h_q.hi_cnt == ZERO_CYC)) else $error("bit pulse of wrong width");
    AST_GAP_WIDTH: assert property ($rose(serial_data) && !h_q.armed
        |-> (h_q.lo_cnt == GAP_CYC || h_q.lo_cnt == GAP_CYC + 1)) else $error("gap of wrong width");
    AST_LEAD_TIME: assert property ($rose(serial_data) && h_q.armed
        |-> h_q.lead_cnt >= INTERVAL_CYC + 1 && h_q.lead_cnt <= INTERVAL_CYC + 3) else $error("lead too short");
    AST_LEAD_BOUND: assert property (h_q.armed |-> h_q.lead_cnt <= INTERVAL_CYC + 3)
        else $error("frame did not start in time");
    AST_REMEASURE: assert property ($rose(read_req_n) && h_q.frame_seen |-> ##[1:3] meas_start)
        else $error("no measurement after transfer");
    AST_SLEEP_AFTER: assert property (h_q.meas_pend && meas_done && read_req_n |=> !power_on_control)
        else $error("no power-down after measurement");
    AST_BOOT_TIME: assert property (meas_start && !h_q.started
        |-> h_q.boot_cnt >= RESET_CYC && h_q.boot_cnt <= RESET_CYC + 2) else $error("boot measurement mistimed");
    AST_WAKE: assert property (!power_on_control && !read_req_n |=> power_on_control)
        else $error("request did not wake module");
    AST_START_PULSE: assert property (meas_start |=> !meas_start)
        else $error("measurement request longer than one cycle");
endmodule // htf_readout_props

bind htf_readout htf_readout_props #(.RESET_CYC(RESET_CYC), .INTERVAL_CYC(INTERVAL_CYC), .ZERO_CYC(ZERO_CYC),
    .ONE_CYC(ONE_CYC), .GAP_CYC(GAP_CYC)) u_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .read_req_n(read_req_n), .serial_data(serial_data), .meas_start(meas_start), .meas_done(meas_done),
    .meas_temp_tenths(meas_temp_tenths), .meas_humidity(meas_humidity),
    .meas_ext_temp_tenths(meas_ext_temp_tenths), .power_on_control(power_on_control));
`default_nettype wire

/* File: htf_host_rx.sv */
// Host-side receiver model that turns pulse widths back into bytes.
`timescale 1ns/1ps
`default_nettype none

module htf_host_rx #(
    parameter int ONE_CYC  = 2,
    parameter int ZERO_CYC = 6
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Serial link
    input wire logic        read_req_n,
    input wire logic        serial_data,
    // Received bytes
    output logic            rx_valid,
    output logic [7:0]      rx_byte
);
    int          width;
    int          nbit;
    logic [7:0]  shreg;
    logic        bit_val;

    assign bit_val = (width < (ONE_CYC + ZERO_CYC) / 2);

    always @(posedge clk_sys) begin
        rx_valid <= 1'b0;
        // A released request drops any partial byte, as the frame is not resumed.
        if (!reset_n || read_req_n) begin
            width <= 0;
            nbit <= 0;
        end else if (serial_data) begin
            width <= width + 1;
        end else if (width != 0) begin
            shreg <= {shreg[6:0], bit_val};
            width <= 0;
            nbit <= (nbit == 7) ? 0 : nbit + 1;
            if (nbit == 7) begin
                rx_valid <= 1'b1;
                rx_byte <= {shreg[6:0], bit_val};
            end
        end
    end
endmodule // htf_host_rx
`default_nettype wire

/* File: tb_htf_readout.sv */
// Self-checking testbench of the frame readout.
`timescale 1ns/1ps
`default_nettype none

module tb_htf_readout;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        read_req_n = 1'b0;
    logic        meas_done = 1'b0;
    logic [15:0] meas_temp_tenths = 16'h0000;
    logic [15:0] meas_ext_temp_tenths = 16'h0000;
    logic [7:0]  meas_humidity = 8'h00;
    logic        serial_data;
    logic        meas_start;
    logic        power_on_control;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic [7:0]  stored [6];
    logic [7:0]  exp_q [$];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          n_rx = 0;
    int          n_done = 0;
    int          seed = 31330;

    always #20 clk_sys = ~clk_sys;

    htf_readout #(.RESET_CYC(20), .INTERVAL_CYC(10), .ZERO_CYC(6), .ONE_CYC(2), .GAP_CYC(2)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .read_req_n(read_req_n), .serial_data(serial_data),
        .meas_start(meas_start), .meas_done(meas_done), .meas_temp_tenths(meas_temp_tenths),
        .meas_humidity(meas_humidity), .meas_ext_temp_tenths(meas_ext_temp_tenths),
        .power_on_control(power_on_control));
    // The host model's default bit widths already match the shortened timing above.
    htf_host_rx u_host (.clk_sys(clk_sys), .reset_n(reset_n),
        .read_req_n(read_req_n), .serial_data(serial_data), .rx_valid(rx_valid), .rx_byte(rx_byte));

    // ==========================================================================
    // Expected frame arithmetic
    function automatic logic [7:0] crc_byte(logic [7:0] c, logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = (b[i] !== c[7]) ? ({c[6:0], 1'b1} ^ 8'h30) : {c[6:0], 1'b0};
        return c;
    endfunction

    function automatic int pick_temp(int k);
        int r;
        r = $random(seed);
        // The first two conversions sit on the ends of the temperature range.
        return (k == 0) ? -400 : (k == 1) ? 700 : ((r < 0) ? -r : r) % 1101 - 400;
    endfunction

    // ==========================================================================
    // Sensor front end, answering after a random delay
    initial begin : front_end
        logic [15:0] t;
        logic [15:0] e;
        logic [7:0]  h;
        forever begin
            @(posedge clk_sys) #1;
            if (meas_start === 1'b1) begin
                t = 16'(pick_temp(n_done));
                e = 16'(pick_temp(n_done + 2));
                h = 8'($random(seed));
                repeat (1 + ($random(seed) & 7)) @(posedge clk_sys);
                meas_temp_tenths <= t;
                meas_ext_temp_tenths <= e;
                meas_humidity <= h;
                meas_done <= 1'b1;
                t = t + 16'h0190;
                e = e + 16'h0190;
                stored = '{t[15:8], t[7:0], h, e[15:8], e[7:0], 8'h00};
                for (int i = 0; i < 5; i++) stored[5] = crc_byte(stored[5], stored[i]);
                @(posedge clk_sys);
                meas_done <= 1'b0;
                n_done++;
            end
        end
    end

    // ==========================================================================
    // Result watcher
    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            n_rx++;
            samples_checked++;
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[FAIL] %0t byte received with none expected", $time);
            end else if (rx_byte !== exp_q.pop_front()) begin
                n_errors++;
                $display("[FAIL] %0t frame byte mismatch", $time);
            end
        end
    end

    // ==========================================================================
    // Tasks
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_cnt(input int sel, input int target);
        int k;
        for (k = 0; k < 3000 && ((sel == 0) ? n_rx : n_done) < target; k++) @(posedge clk_sys);
        if (k == 3000) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            give_verdict();
        end
    endtask

    task automatic do_read(input int nb);
        int base;
        base = n_rx;
        for (int k = 0; k < nb; k++) exp_q.push_back(stored[k]);
        @(posedge clk_sys);
        read_req_n <= 1'b0;
        wait_cnt(0, base + nb);
        @(posedge clk_sys);
        read_req_n <= 1'b1;
        base = n_done;
        wait_cnt(1, base + 1);
        repeat (3) @(posedge clk_sys);
        #1;
        samples_checked++;
        if (power_on_control !== 1'b0) begin
            n_errors++;
            $display("[FAIL] %0t module did not power down", $time);
        end
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_cnt(1, 1);
        do_read(6);
        for (int k = 0; k < 3; k++) begin
            repeat (1 + ($random(seed) & 15)) @(posedge clk_sys);
            do_read(6);
        end
        do_read(2);
        do_read(6);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_cnt(1, n_done + 1);
        do_read(6);
        samples_checked++;
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("[FAIL] %0t bytes missing at end", $time);
        end
        give_verdict();
    end
endmodule // tb_htf_readout
`default_nettype wire
